// [core/llcg_dead_arb.sv]
// dead-time arbiter: picks the moment the next gate may turn on
`timescale 1ns/1ps
`default_nettype none
module llcg_dead_arb
	import llcg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	llcg_dead_if.arb dif
);

	logic [CNT_W-1:0] cnt_q;
	logic active_q;
	logic blank_done;
	logic timeout;
	logic flip_ok;

	// ------------------------------------------------------------
	// turn-on decision
	// ------------------------------------------------------------
	assign blank_done = (cnt_q >= BLANK_CNT);
	assign flip_ok = dif.dir_flip & blank_done;
	assign timeout = (cnt_q == TIMEOUT_CNT);
	// slew done wins; the others only matter without it
	assign dif.turn_on = active_q & (dif.slew_done | flip_ok | timeout);
	assign dif.cause = !active_q ? CAUSE_NONE :
		dif.slew_done ? CAUSE_SLEW :
		flip_ok ? CAUSE_FLIP :
		timeout ? CAUSE_TIMEOUT : CAUSE_NONE;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= CNT_RESET;
			active_q <= 1'b0;
		end else if (dif.dead_start) begin
			cnt_q <= CNT_RESET;
			active_q <= 1'b1;
		end else if (dif.turn_on) begin
			active_q <= 1'b0;
		end else if (active_q) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_blank_ignores_flip: assert property (@(posedge clk) disable iff (!reset_n)
		(active_q && cnt_q < BLANK_CNT && !dif.slew_done && !timeout)
		|-> !dif.turn_on) else $error("flip honoured inside blanking");
	a_dead_bounded: assert property (@(posedge clk) disable iff (!reset_n)
		active_q |-> cnt_q <= TIMEOUT_CNT)
		else $error("dead time ran past its maximum");
	a_slew_first: assert property (@(posedge clk) disable iff (!reset_n)
		(active_q && dif.slew_done) |-> dif.cause == CAUSE_SLEW)
		else $error("slew done not given priority");
	a_flip_turns_on: assert property (@(posedge clk) disable iff (!reset_n)
		(active_q && blank_done && dif.dir_flip) |-> dif.turn_on)
		else $error("flip after blanking missed");
	c_timeout_turn_on: cover property (@(posedge clk) disable iff (!reset_n)
		dif.turn_on && dif.cause == CAUSE_TIMEOUT);
	c_flip_turn_on: cover property (@(posedge clk) disable iff (!reset_n)
		dif.turn_on && dif.cause == CAUSE_FLIP);

endmodule // llcg_dead_arb
`default_nettype wire

// [core/llcg_dead_if.sv]
// carrier between the sequencer and the dead-time arbiter
`timescale 1ns/1ps
`default_nettype none
interface llcg_dead_if;
	import llcg_pkg::*;
	logic dead_start;
	logic slew_done;
	logic dir_flip;
	logic turn_on;
	llcg_cause_t cause;
	modport seq (output dead_start, output slew_done, output dir_flip,
		input turn_on, input cause);
	modport arb (input dead_start, input slew_done, input dir_flip,
		output turn_on, output cause);
endinterface
`default_nettype wire

// [core/llcg_gate_seq.sv]
// half-bridge gate sequencer with capacitive-region guard and bulk checks
// Function
// - next gate waits for slew done
// - slew done is primary turn-on condition
// - without slew, turn on at current flip
// - otherwise turn on at max dead time
// - sample current at on-command falls, flag capacitive
// - flag clears after a clean half cycle
// - capacitive flag pulls soft-start node down
// - start only above bulk start level
// - stop when bulk falls to stop level
// - one comparator, threshold chosen by fault
// - set at rise level, clear below fall
// - hold aux sample at low-side turn-off
// - held sample above threshold raises overvoltage
// - lockouts from driver supply and bootstrap
// - driver low power during burst off
// - ignore current flips in first 400ns
// - charge only enabled, not done, no capacitive fault
// - driver supply low forces both gates off
// - bootstrap low forces high gate off
`timescale 1ns/1ps
`default_nettype none
module llcg_gate_seq
	import llcg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slew_done_in,
	input wire logic current_direction,
	input wire logic bulk_start_level,
	input wire logic bulk_stop_level,
	input wire logic bulk_sense_level,
	input wire logic driver_supply_rail,
	input wire logic bootstrap_rail,
	input wire logic run_enable,
	input wire logic burst_off,
	input wire logic turn_off_req,
	input wire logic soft_start_enable,
	input wire logic soft_start_done,
	input wire logic [AUX_W-1:0] aux_winding_sense,
	output logic high_on_cmd,
	output logic low_on_cmd,
	output logic high_gate_out,
	output logic low_gate_out,
	output logic capacitive_fault,
	output logic soft_start_pulldown,
	output logic soft_start_charge,
	output logic bulk_overvoltage_fault,
	output logic bulk_ov_fall_select,
	output logic output_overvoltage_fault,
	output logic [AUX_W-1:0] aux_sample,
	output logic switching_active,
	output logic driver_low_power
);

	function automatic logic is_on(input llcg_state_t s);
		return (s == ST_HIGH) || (s == ST_LOW);
	endfunction

	llcg_dead_if dif ();
	llcg_dead_arb u_arb (.clk(clk), .reset_n(reset_n), .dif(dif.arb));

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic slew_q;
	logic dir_q;
	logic [SYN_W-1:0] pins;
	assign pins = {bootstrap_rail, driver_supply_rail, bulk_sense_level,
		bulk_stop_level, bulk_start_level, current_direction, slew_done_in};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syn1_q <= SYN_RESET;
			syn2_q <= SYN_RESET;
			slew_q <= 1'b0;
			dir_q <= 1'b0;
		end else begin
			syn1_q <= pins;
			syn2_q <= syn1_q;
			slew_q <= syn2_q[SYN_SLEW];
			dir_q <= syn2_q[SYN_DIR];
		end
	end

	logic dir_pos;
	logic drv_ok;
	logic boot_ok;
	logic bulk_ov_cmp;
	assign dir_pos = syn2_q[SYN_DIR];
	assign drv_ok = syn2_q[SYN_DRV];
	assign boot_ok = syn2_q[SYN_BOOT];
	assign bulk_ov_cmp = syn2_q[SYN_OV];
	assign dif.slew_done = syn2_q[SYN_SLEW] & ~slew_q;
	assign dif.dir_flip = dir_pos ^ dir_q;

	// ------------------------------------------------------------
	// bulk supervision
	// ------------------------------------------------------------
	logic bulk_ov_q;
	logic bulk_ov_d;
	logic run_q;
	logic run_d;
	logic stop_cond;
	// comparator sees the rise level while clear, the fall level while set
	assign bulk_ov_d = bulk_ov_q ? bulk_ov_cmp : bulk_ov_cmp;
	assign stop_cond = syn2_q[SYN_STOP] | ~run_enable | burst_off |
		bulk_ov_q;
	assign run_d = stop_cond ? 1'b0 :
		(syn2_q[SYN_START] ? 1'b1 : run_q);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bulk_ov_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			bulk_ov_q <= bulk_ov_d;
			run_q <= run_d;
		end
	end
	assign bulk_overvoltage_fault = bulk_ov_q;
	assign bulk_ov_fall_select = bulk_ov_q;
	assign switching_active = run_q;

	// ------------------------------------------------------------
	// gate sequence
	// ------------------------------------------------------------
	llcg_state_t state_q;
	llcg_state_t state_d;
	logic leave_on;
	assign leave_on = turn_off_req | ~run_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
		ST_IDLE: begin
			if (run_q) begin
				state_d = ST_LOW;
			end
		end
		ST_HIGH: begin
			if (leave_on) begin
				state_d = ST_DEAD_TO_LOW;
			end
		end
		ST_DEAD_TO_LOW: begin
			if (!run_q) begin
				state_d = ST_IDLE;
			end else if (dif.turn_on) begin
				state_d = ST_LOW;
			end
		end
		ST_LOW: begin
			if (leave_on) begin
				state_d = ST_DEAD_TO_HIGH;
			end
		end
		ST_DEAD_TO_HIGH: begin
			if (!run_q) begin
				state_d = ST_IDLE;
			end else if (dif.turn_on) begin
				state_d = ST_HIGH;
			end
		end
		default: state_d = ST_IDLE;
		endcase
	end

	logic fall_hi;
	logic fall_lo;
	assign fall_hi = (state_q == ST_HIGH) && (state_d != ST_HIGH);
	assign fall_lo = (state_q == ST_LOW) && (state_d != ST_LOW);
	assign dif.dead_start = is_on(state_q) && !is_on(state_d);

	logic hi_gate_q;
	logic lo_gate_q;
	logic lp_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			hi_gate_q <= 1'b0;
			lo_gate_q <= 1'b0;
			lp_q <= 1'b0;
		end else begin
			state_q <= state_d;
			hi_gate_q <= (state_d == ST_HIGH) & drv_ok & boot_ok;
			lo_gate_q <= (state_d == ST_LOW) & drv_ok;
			lp_q <= burst_off & (state_d == ST_IDLE);
		end
	end
	assign high_on_cmd = (state_q == ST_HIGH);
	assign low_on_cmd = (state_q == ST_LOW);
	assign high_gate_out = hi_gate_q;
	assign low_gate_out = lo_gate_q;
	assign driver_low_power = lp_q;

	// ------------------------------------------------------------
	// capacitive-region guard and soft start
	// ------------------------------------------------------------
	logic cap_q;
	logic cap_d;
	logic cap_event;
	logic half_end;
	assign cap_event = (fall_lo & dir_pos) | (fall_hi & ~dir_pos);
	assign half_end = fall_hi | fall_lo;
	// a new event wins over the clean-half-cycle clear
	assign cap_d = cap_event ? 1'b1 : (half_end ? 1'b0 : cap_q);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_q <= 1'b0;
		end else begin
			cap_q <= cap_d;
		end
	end
	assign capacitive_fault = cap_q;
	assign soft_start_pulldown = cap_q;
	assign soft_start_charge = soft_start_enable & ~soft_start_done &
		~cap_q;

	// ------------------------------------------------------------
	// output-voltage sample and hold
	// ------------------------------------------------------------
	logic [AUX_W-1:0] aux_q;
	logic ovp_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_q <= AUX_RESET;
			ovp_q <= 1'b0;
		end else begin
			if (fall_lo) begin
				aux_q <= aux_winding_sense;
			end
			ovp_q <= (aux_q > AUX_OV_LEVEL);
		end
	end
	assign aux_sample = aux_q;
	assign output_overvoltage_fault = ovp_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_no_overlap: assert property (@(posedge clk) disable iff (!reset_n)
		!(high_on_cmd && low_on_cmd) && !(high_gate_out && low_gate_out))
		else $error("both gates on");
	a_dead_after_high: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(high_on_cmd) |-> !low_on_cmd)
		else $error("no dead time after high side");
	a_cap_set: assert property (@(posedge clk) disable iff (!reset_n)
		cap_event |=> capacitive_fault && soft_start_pulldown)
		else $error("capacitive event not flagged");
	a_cap_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(half_end && !cap_event) |=> !capacitive_fault)
		else $error("flag kept after clean half cycle");
	a_charge_gate: assert property (@(posedge clk) disable iff (!reset_n)
		soft_start_charge |-> soft_start_enable && !soft_start_done &&
		!capacitive_fault) else $error("charge while blocked");
	a_drv_uvlo: assert property (@(posedge clk) disable iff (!reset_n)
		!drv_ok |=> !high_gate_out && !low_gate_out)
		else $error("gate on under driver lockout");
	a_boot_uvlo: assert property (@(posedge clk) disable iff (!reset_n)
		!boot_ok |=> !high_gate_out)
		else $error("high gate on under bootstrap lockout");
	a_bulk_stop: assert property (@(posedge clk) disable iff (!reset_n)
		syn2_q[SYN_STOP] |=> !switching_active ##1 !is_on(state_q))
		else $error("switching kept below stop level");
	a_bulk_ov_set: assert property (@(posedge clk) disable iff (!reset_n)
		(!bulk_ov_q && bulk_ov_cmp) |=> bulk_overvoltage_fault &&
		bulk_ov_fall_select) else $error("overvoltage not set");
	a_aux_hold: assert property (@(posedge clk) disable iff (!reset_n)
		fall_lo |=> aux_sample == $past(aux_winding_sense) ##1
		output_overvoltage_fault == (aux_sample > AUX_OV_LEVEL))
		else $error("aux sample not held or compared");
	c_cap_event: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(capacitive_fault));
	c_bulk_ov: cover property (@(posedge clk) disable iff (!reset_n)
		$fell(bulk_overvoltage_fault));
	c_full_cycle: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(high_on_cmd) ##[1:1000] $rose(low_on_cmd));

endmodule // llcg_gate_seq
`default_nettype wire

// [core/llcg_pkg.sv]
// constants and types shared by the gate sequencer and its dead-time arbiter
package llcg_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int BLANK_NS = 400;
	localparam int MAX_DEAD_NS = 1000;
	// least time: round up
	localparam int BLANK_CYC = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;
	// longest time: round down
	localparam int MAX_DEAD_CYC = (MAX_DEAD_NS * 1000) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
	localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(BLANK_CYC);
	localparam logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(MAX_DEAD_CYC - 1);

	// ------------------------------------------------------------
	// pin synchroniser bit positions
	// ------------------------------------------------------------
	localparam int SYN_W = 7;
	localparam int SYN_SLEW = 0;
	localparam int SYN_DIR = 1;
	localparam int SYN_START = 2;
	localparam int SYN_STOP = 3;
	localparam int SYN_OV = 4;
	localparam int SYN_DRV = 5;
	localparam int SYN_BOOT = 6;
	localparam logic [SYN_W-1:0] SYN_RESET = 7'h00;

	// ------------------------------------------------------------
	// output-voltage sample
	// ------------------------------------------------------------
	localparam int AUX_W = 10;
	localparam logic [AUX_W-1:0] AUX_RESET = 10'h000;
	localparam logic [AUX_W-1:0] AUX_OV_LEVEL = 10'h300;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HIGH = 5'h02,
		ST_DEAD_TO_LOW = 5'h04,
		ST_LOW = 5'h08,
		ST_DEAD_TO_HIGH = 5'h10
	} llcg_state_t;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0,
		CAUSE_SLEW = 2'h1,
		CAUSE_FLIP = 2'h2,
		CAUSE_TIMEOUT = 2'h3
	} llcg_cause_t;

endpackage

// [verification/llcg_drv_model.sv]
// half-bridge stage model: switch-node slew and resonant current direction
`timescale 1ns/1ps
`default_nettype none
module llcg_drv_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic high_gate_out,
	input wire logic low_gate_out,
	input wire logic [1:0] mode,
	input wire logic [7:0] delay,
	input wire logic dir_load,
	input wire logic dir_val,
	output logic slew_done_in,
	output logic current_direction
);
	// mode 0: silent node, 1: slew finishes, 2: current flips
	logic [1:0] g_q;
	logic [7:0] cnt_q;
	logic run_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			g_q <= 2'h0;
			cnt_q <= 8'h00;
			run_q <= 1'b0;
			slew_done_in <= 1'b0;
			current_direction <= 1'b0;
		end else begin
			g_q <= {high_gate_out, low_gate_out};
			slew_done_in <= 1'b0;
			if (g_q != 2'h0 && !high_gate_out && !low_gate_out) begin
				cnt_q <= 8'h00;
				run_q <= 1'b1;
			end else if (run_q) begin
				cnt_q <= cnt_q + 8'h01;
			end
			if (run_q && cnt_q == delay) begin
				run_q <= 1'b0;
				slew_done_in <= (mode == 2'h1);
				if (mode == 2'h2)
					current_direction <= ~current_direction;
			end
			if (dir_load)
				current_direction <= dir_val;
		end
	end
endmodule // llcg_drv_model
`default_nettype wire

// [verification/llcg_gate_seq_tb.sv]
// self-checking bench for the gate sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module llcg_gate_seq_tb;
	import llcg_pkg::*;
	logic clk = 0, reset_n = 0, slew, dir;
	logic st = 0, sp = 0, bs = 0, drv = 1, boot = 1, run = 1, burst = 0;
	logic toff = 0, sse = 1, ssd = 0, dload = 0, dval = 0;
	logic [AUX_W-1:0] aux = 10'h000;
	logic [1:0] mode = 2'h0;
	logic [7:0] dly = 8'h00;
	logic ho, lo, hg, lg, cf, pd, chg, bov, fsel, oov, act, lp;
	logic [AUX_W-1:0] smp;
	int errors = 0, check_count = 0, seed = 3707, n, i;
	always #2.5 clk = ~clk;
	llcg_gate_seq dut (.clk(clk), .reset_n(reset_n), .slew_done_in(slew),
		.current_direction(dir), .bulk_start_level(st),
		.bulk_stop_level(sp), .bulk_sense_level(bs),
		.driver_supply_rail(drv), .bootstrap_rail(boot),
		.run_enable(run), .burst_off(burst), .turn_off_req(toff),
		.soft_start_enable(sse), .soft_start_done(ssd),
		.aux_winding_sense(aux), .high_on_cmd(ho), .low_on_cmd(lo),
		.high_gate_out(hg), .low_gate_out(lg), .capacitive_fault(cf),
		.soft_start_pulldown(pd), .soft_start_charge(chg),
		.bulk_overvoltage_fault(bov), .bulk_ov_fall_select(fsel),
		.output_overvoltage_fault(oov), .aux_sample(smp),
		.switching_active(act), .driver_low_power(lp));
	llcg_drv_model far (.clk(clk), .reset_n(reset_n), .high_gate_out(hg),
		.low_gate_out(lg), .mode(mode), .delay(dly), .dir_load(dload),
		.dir_val(dval), .slew_done_in(slew), .current_direction(dir));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic pick(input int w);
		case (w)
			0: pick = lo;
			1: pick = ho;
			2: pick = act;
			3: pick = bov;
			default: pick = lp;
		endcase
	endfunction
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait; an expired bound ends the run
	task automatic wait_for(input int w, input logic v);
		for (int k = 0; k < 600; k++) begin
			cyc(1);
			if (pick(w) === v)
				return;
		end
		errors++;
		$display("mismatch at %0t: wait expired", $time);
		wrap_up();
	endtask
	task automatic set_dir(input logic v);
		@(posedge clk);
		dload <= 1'b1;
		dval <= v;
		@(posedge clk);
		dload <= 1'b0;
		cyc(4);
	endtask
	// ends the current on period and counts the dead cycles; the
	// command drops at the edge that takes the pulse, so counting
	// starts just after that edge
	task automatic dead_run(output int cnt);
		@(posedge clk);
		toff <= 1'b1;
		aux <= 10'($random(seed));
		@(posedge clk);
		toff <= 1'b0;
		#1;
		cnt = 0;
		while (!ho && !lo && cnt < 400) begin
			cnt++;
			cyc(1);
		end
		if (cnt >= 400) begin
			errors++;
			$display("mismatch at %0t: dead time never ended", $time);
			wrap_up();
		end
		cyc(2);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc(12);
		reset_n = 1'b1;
		cyc(20);
		`CHK(act, 1'b0)
		st <= 1'b1;
		wait_for(0, 1'b1);
		`CHK(hg, 1'b0)
		mode <= 2'h0;
		dead_run(n);
		`CHK(n, 200)
		`CHK(lo, 1'b0)
		`CHK(smp, aux)
		`CHK(oov, 1'(aux > AUX_OV_LEVEL))
		for (i = 0; i < 6; i++) begin
			mode <= 2'h1;
			dly <= 8'(2 + ($random(seed) & 32'h1f));
			dead_run(n);
			`CHK((n >= dly && n <= dly + 6), 1'b1)
		end
		mode <= 2'h2;
		dly <= 8'h14;
		dead_run(n);
		`CHK(n, 200)
		dly <= 8'h78;
		dead_run(n);
		`CHK((n >= 120 && n < 130), 1'b1)
		mode <= 2'h0;
		// wrong polarity at the next fall, then a clean one
		set_dir(lo);
		dead_run(n);
		`CHK(cf, 1'b1)
		`CHK(pd, 1'b1)
		`CHK(chg, 1'b0)
		// clean polarity: negative at a low fall, positive at a high fall
		set_dir(!lo);
		dead_run(n);
		`CHK(cf, 1'b0)
		`CHK(chg, 1'b1)
		ssd <= 1'b1;
		cyc(1);
		`CHK(chg, 1'b0)
		ssd <= 1'b0;
		if (!ho)
			dead_run(n);
		boot <= 1'b0;
		cyc(5);
		`CHK({ho, hg}, 2'b10)
		boot <= 1'b1;
		dead_run(n);
		drv <= 1'b0;
		cyc(5);
		`CHK({lo, lg, hg}, 3'b100)
		drv <= 1'b1;
		bs <= 1'b1;
		wait_for(3, 1'b1);
		`CHK(fsel, 1'b1)
		cyc(4);
		`CHK({act, ho, lo}, 3'b000)
		bs <= 1'b0;
		wait_for(3, 1'b0);
		`CHK(fsel, 1'b0)
		wait_for(0, 1'b1);
		sp <= 1'b1;
		wait_for(2, 1'b0);
		cyc(3);
		`CHK({ho, lo}, 2'b00)
		sp <= 1'b0;
		wait_for(0, 1'b1);
		run <= 1'b0;
		wait_for(2, 1'b0);
		cyc(3);
		`CHK({ho, lo}, 2'b00)
		run <= 1'b1;
		wait_for(0, 1'b1);
		burst <= 1'b1;
		wait_for(4, 1'b1);
		`CHK({hg, lg}, 2'b00)
		burst <= 1'b0;
		wait_for(0, 1'b1);
		`CHK(lp, 1'b0)
		wrap_up();
	end
endmodule // llcg_gate_seq_tb
`default_nettype wire
